// >>> hw/uhc_pkg.sv
// uhc_pkg: command codes, field layout, reset values and timing for the host control registers
// assumes a 25 MHz controller clock and a 16-bit command/data port
package uhc_pkg;
	localparam int          CLK_HZ           = 25000000;
	localparam int          SOF_DELAY_US     = 1000;
	localparam int          SOF_DELAY_CYC    = (CLK_HZ / 1000000) * SOF_DELAY_US;

	localparam logic [7:0]  CMD_CTRL_RD      = 8'h01;
	localparam logic [7:0]  CMD_CTRL_WR      = 8'h81;
	localparam logic [7:0]  CMD_CSTAT_RD     = 8'h02;
	localparam logic [7:0]  CMD_CSTAT_WR     = 8'h82;

	localparam int          CTRL_RWE_BIT     = 10;
	localparam int          CTRL_RWC_BIT     = 9;
	localparam int          CTRL_FS_LSB      = 6;
	localparam int          CSTAT_HCR_BIT    = 0;
	localparam int          CSTAT_SOC_LSB    = 16;

	localparam logic [1:0]  FS_RESET_VAL     = 2'h0;
	localparam logic [1:0]  SOC_RESET_VAL    = 2'h0;
	localparam logic [1:0]  SOC_STEP         = 2'h1;
	localparam logic [31:0] WORD_ZERO        = 32'h0;

	typedef enum logic [1:0] {
		STATE_BUS_RESET   = 2'h0,
		STATE_RESUME      = 2'h1,
		STATE_OPERATIONAL = 2'h2,
		STATE_SUSPEND     = 2'h3
	} uhc_fstate_t;

	typedef enum logic [4:0] {
		PH_IDLE  = 5'h01,
		PH_RD_LO = 5'h02,
		PH_RD_HI = 5'h04,
		PH_WR_LO = 5'h08,
		PH_WR_HI = 5'h10
	} uhc_phase_t;
endpackage

// >>> hw/uhc_sof_delay.sv
// uhc_sof_delay: counts the wait between entering operational and the first frame start
// assumes start and cancel are one-cycle or level inputs synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module uhc_sof_delay #(
	parameter int COUNT = 25000
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire logic cancel,
	output logic      done
);
	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic        run_ff;
	logic        nxt_run;
	logic        done_ff;
	logic        nxt_done;

	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_run  = run_ff;
		nxt_done = done_ff;
		if (cancel) begin
			nxt_run  = 1'b0;
			nxt_done = 1'b0;
		end else if (start) begin
			nxt_cnt  = 32'h1;
			nxt_run  = 1'b1;
			nxt_done = 1'b0;
		end else if (run_ff) begin
			if (cnt_ff >= 32'(COUNT)) begin
				nxt_run  = 1'b0;
				nxt_done = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff  <= 32'h0;
			run_ff  <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			run_ff  <= nxt_run;
			done_ff <= nxt_done;
		end
	end

	assign done = done_ff;
endmodule // uhc_sof_delay
`default_nettype wire

// >>> hw/uhc_command_regs.sv
// uhc_command_regs: operating control and command/status registers of the host controller
// assumes a 16-bit command/data port with one-cycle strobes synchronous to CLK
`timescale 1ns/1ps
`default_nettype none
module uhc_command_regs
	import uhc_pkg::*;
#(
	parameter int SOF_DELAY = SOF_DELAY_CYC
) (
	input  wire logic        CLK,
	input  wire logic        RESETN,
	input  wire logic        HOST_WR,
	input  wire logic        HOST_RD,
	input  wire logic        HOST_A0,
	input  wire logic [15:0] HOST_DIN,
	output logic      [15:0] HOST_DOUT,
	input  wire logic        RESUME_DETECTED,
	input  wire logic        DOWNSTREAM_RESUME,
	input  wire logic        SCHED_OVERRUN,
	output logic             REMOTE_WAKEUP,
	output logic             SOF_ENABLE,
	output logic       [1:0] FUNCTIONAL_STATE,
	output logic             ROOT_HUB_RESET,
	output logic             SOFT_RESET
);
	logic        rst_meta_ff;
	logic        rst_sync_ff;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// register image helpers
	function automatic logic [31:0] ctrl_image(input logic remote_wakeup_enable, input logic remote_wakeup_connected,
		input logic [1:0] fs);
		logic [31:0] w;
		w = WORD_ZERO;
		w[CTRL_RWE_BIT] = remote_wakeup_enable;
		w[CTRL_RWC_BIT] = remote_wakeup_connected;
		w[CTRL_FS_LSB +: 2] = fs;
		return w;
	endfunction

	function automatic logic [31:0] cstat_image(input logic hcr, input logic [1:0] soc);
		logic [31:0] w;
		w = WORD_ZERO;
		w[CSTAT_HCR_BIT] = hcr;
		w[CSTAT_SOC_LSB +: 2] = soc;
		return w;
	endfunction

	uhc_phase_t  phase_ff;
	uhc_phase_t  nxt_phase;
	logic [7:0]  code_ff;
	logic [7:0]  nxt_code;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [15:0] wlo_ff;
	logic [15:0] nxt_wlo;
	logic [15:0] dout_ff;
	logic [15:0] nxt_dout;

	logic        rwe_ff;
	logic        nxt_rwe;
	logic        rwc_ff;
	logic        nxt_rwc;
	logic [1:0]  fs_ff;
	logic [1:0]  nxt_fs;
	logic        hcr_ff;
	logic        nxt_hcr;
	logic [1:0]  soc_ff;
	logic [1:0]  nxt_soc;
	logic        rh_rst_ff;
	logic        sw_rst_ff;
	logic        nxt_sw_rst;

	logic [31:0] wr_word;
	logic        wr_commit;
	logic        sof_start;
	logic        sof_cancel;
	logic        sof_done;

	assign wr_word   = {HOST_DIN, wlo_ff};
	assign wr_commit = (phase_ff == PH_WR_HI) && HOST_WR && !HOST_A0;

	// command/data sequencer: code, then low word, then high word
	always_comb begin
		nxt_phase = phase_ff;
		nxt_code  = code_ff;
		nxt_rdata = rdata_ff;
		nxt_wlo   = wlo_ff;
		nxt_dout  = dout_ff;
		if (HOST_WR && HOST_A0) begin
			nxt_code = HOST_DIN[7:0];
			case (HOST_DIN[7:0])
				CMD_CTRL_RD: begin
					nxt_rdata = ctrl_image(rwe_ff, rwc_ff, fs_ff);
					nxt_phase = PH_RD_LO;
				end
				CMD_CSTAT_RD: begin
					nxt_rdata = cstat_image(hcr_ff, soc_ff);
					nxt_phase = PH_RD_LO;
				end
				CMD_CTRL_WR, CMD_CSTAT_WR: begin
					nxt_phase = PH_WR_LO;
				end
				default: begin
					nxt_rdata = WORD_ZERO;
					nxt_phase = PH_IDLE;
				end
			endcase
			nxt_dout = nxt_rdata[15:0];
		end else begin
			case (phase_ff)
				PH_RD_LO: begin
					if (HOST_RD && !HOST_A0) begin
						nxt_dout  = rdata_ff[31:16];
						nxt_phase = PH_RD_HI;
					end
				end
				PH_RD_HI: begin
					if (HOST_RD && !HOST_A0) begin
						nxt_phase = PH_IDLE;
					end
				end
				PH_WR_LO: begin
					if (HOST_WR && !HOST_A0) begin
						nxt_wlo   = HOST_DIN;
						nxt_phase = PH_WR_HI;
					end
				end
				PH_WR_HI: begin
					if (HOST_WR && !HOST_A0) begin
						nxt_phase = PH_IDLE;
					end
				end
				default: begin
					nxt_phase = PH_IDLE;
				end
			endcase
		end
	end

	// register contents
	always_comb begin
		nxt_rwe    = rwe_ff;
		nxt_rwc    = rwc_ff;
		nxt_fs     = fs_ff;
		nxt_hcr    = hcr_ff;
		nxt_soc    = soc_ff;
		nxt_sw_rst = 1'b0;
		if (SCHED_OVERRUN) begin
			nxt_soc = soc_ff + SOC_STEP;
		end
		if (fs_ff == STATE_SUSPEND && DOWNSTREAM_RESUME) begin
			nxt_fs = STATE_RESUME;
		end
		if (wr_commit && code_ff == CMD_CTRL_WR) begin
			nxt_rwe = wr_word[CTRL_RWE_BIT];
			nxt_rwc = wr_word[CTRL_RWC_BIT];
			nxt_fs  = wr_word[CTRL_FS_LSB +: 2];
		end
		if (wr_commit && code_ff == CMD_CSTAT_WR) begin
			nxt_hcr = hcr_ff | wr_word[CSTAT_HCR_BIT];
		end
		if (hcr_ff) begin
			// software reset: keeps connected bit, no root hub reset
			nxt_sw_rst = 1'b1;
			nxt_hcr    = 1'b0;
			nxt_rwe    = 1'b0;
			nxt_fs     = FS_RESET_VAL;
			nxt_soc    = SOC_RESET_VAL;
			nxt_rwc    = rwc_ff;
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			phase_ff  <= PH_IDLE;
			code_ff   <= 8'h00;
			rdata_ff  <= WORD_ZERO;
			wlo_ff    <= 16'h0000;
			dout_ff   <= 16'h0000;
			rwe_ff    <= 1'b0;
			rwc_ff    <= 1'b0;
			fs_ff     <= FS_RESET_VAL;
			hcr_ff    <= 1'b0;
			soc_ff    <= SOC_RESET_VAL;
			rh_rst_ff <= 1'b1;
			sw_rst_ff <= 1'b0;
		end else begin
			phase_ff  <= nxt_phase;
			code_ff   <= nxt_code;
			rdata_ff  <= nxt_rdata;
			wlo_ff    <= nxt_wlo;
			dout_ff   <= nxt_dout;
			rwe_ff    <= nxt_rwe;
			rwc_ff    <= nxt_rwc;
			fs_ff     <= nxt_fs;
			hcr_ff    <= nxt_hcr;
			soc_ff    <= nxt_soc;
			rh_rst_ff <= 1'b0;
			sw_rst_ff <= nxt_sw_rst;
		end
	end

	assign sof_start  = (nxt_fs == STATE_OPERATIONAL) && (fs_ff != STATE_OPERATIONAL);
	assign sof_cancel = (fs_ff != STATE_OPERATIONAL);

	uhc_sof_delay #(
		.COUNT (SOF_DELAY)
	) u_sof_delay (
		.clk    (CLK),
		.rst_n  (rst_sync_ff),
		.start  (sof_start),
		.cancel (sof_cancel && !sof_start),
		.done   (sof_done)
	);

	assign HOST_DOUT        = dout_ff;
	assign REMOTE_WAKEUP    = rwe_ff & RESUME_DETECTED;
	assign SOF_ENABLE       = sof_done;
	assign FUNCTIONAL_STATE = fs_ff;
	assign ROOT_HUB_RESET   = rh_rst_ff | !rst_sync_ff;
	assign SOFT_RESET       = sw_rst_ff;
endmodule // uhc_command_regs
`default_nettype wire

// >>> test/uhc_command_regs_monitor.sv
// uhc_command_regs_monitor: port assertions for uhc_command_regs
// assumes one clock domain; bound into every instance of the block
`timescale 1ns/1ps
`default_nettype none
module uhc_command_regs_mon #(
	parameter int SOF_DELAY = 20
) (
	input wire logic       CLK,
	input wire logic       RESETN,
	input wire logic       HOST_WR,
	input wire logic       RESUME_DETECTED,
	input wire logic       DOWNSTREAM_RESUME,
	input wire logic       REMOTE_WAKEUP,
	input wire logic       SOF_ENABLE,
	input wire logic [1:0] FUNCTIONAL_STATE,
	input wire logic       ROOT_HUB_RESET,
	input wire logic       SOFT_RESET
);
	// cycles spent in operational
	logic [15:0] op_cnt_ff;
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) op_cnt_ff <= 16'h0;
		else if (FUNCTIONAL_STATE != 2'h2) op_cnt_ff <= 16'h0;
		else if (~&op_cnt_ff) op_cnt_ff <= op_cnt_ff + 16'h1;
	end
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	wake_gate_a: assert property (!RESUME_DETECTED |-> !REMOTE_WAKEUP)
		else $error("wake-up without resume");
	sof_off_a: assert property ((FUNCTIONAL_STATE != 2'h2) [*2] |-> !SOF_ENABLE)
		else $error("frame start outside operational");
	sof_early_a: assert property (SOF_ENABLE |-> op_cnt_ff >= SOF_DELAY - 2)
		else $error("frame start too early");
	sof_late_a: assert property (op_cnt_ff >= SOF_DELAY + 4 |-> SOF_ENABLE)
		else $error("frame start too late");
	fs_auto_a: assert property ($changed(FUNCTIONAL_STATE) |->
		$past(HOST_WR) || $past(FUNCTIONAL_STATE) == 2'h3 || SOFT_RESET)
		else $error("state changed on its own");
	resume_move_a: assert property (FUNCTIONAL_STATE == 2'h3 && DOWNSTREAM_RESUME &&
		!HOST_WR |=> FUNCTIONAL_STATE == 2'h1 || SOFT_RESET) else $error("no resume from suspend");
	soft_state_a: assert property (SOFT_RESET |-> FUNCTIONAL_STATE == 2'h0)
		else $error("soft reset left state");
	soft_hub_a: assert property (SOFT_RESET |-> !ROOT_HUB_RESET)
		else $error("soft reset hit root hub");
	soft_pulse_a: assert property (SOFT_RESET |=> !SOFT_RESET)
		else $error("soft reset pulse too long");
	hub_release_a: assert property ($rose(RESETN) |-> (FUNCTIONAL_STATE == 2'h0 &&
		ROOT_HUB_RESET) [*3] ##1 !ROOT_HUB_RESET) else $error("bad hub reset release");
	sof_seen_c: cover property ($rose(SOF_ENABLE));
	soft_seen_c: cover property (SOFT_RESET);
	resume_seen_c: cover property (FUNCTIONAL_STATE == 2'h3 ##1 FUNCTIONAL_STATE == 2'h1);
endmodule // uhc_command_regs_mon
bind uhc_command_regs uhc_command_regs_mon #(.SOF_DELAY(SOF_DELAY)) mon_u (
	.CLK               (CLK),
	.RESETN            (RESETN),
	.HOST_WR           (HOST_WR),
	.RESUME_DETECTED   (RESUME_DETECTED),
	.DOWNSTREAM_RESUME (DOWNSTREAM_RESUME),
	.REMOTE_WAKEUP     (REMOTE_WAKEUP),
	.SOF_ENABLE        (SOF_ENABLE),
	.FUNCTIONAL_STATE  (FUNCTIONAL_STATE),
	.ROOT_HUB_RESET    (ROOT_HUB_RESET),
	.SOFT_RESET        (SOFT_RESET)
);
`default_nettype wire

// >>> test/uhc_command_regs_tb.sv
// uhc_command_regs_tb: self-checking bench for the host control registers
// assumes uhc_pkg, the design and the monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module uhc_command_regs_tb;
	import uhc_pkg::*;
	localparam int SD = 20;
	logic        CLK = 0, RESETN = 0, HOST_WR = 0, HOST_RD = 0, HOST_A0 = 0, smp = 0;
	logic        RESUME_DETECTED = 0, DOWNSTREAM_RESUME = 0, SCHED_OVERRUN = 0;
	logic        REMOTE_WAKEUP, SOF_ENABLE, ROOT_HUB_RESET, SOFT_RESET;
	logic [15:0] HOST_DIN = 16'h0, HOST_DOUT, e;
	logic [1:0]  FUNCTIONAL_STATE;
	logic [15:0] exp_q[$];
	logic [31:0] seed = 32'h1066f, w;
	int          num_errors = 0, num_checks = 0, n;
	uhc_command_regs #(.SOF_DELAY(SD)) dut_u (
		.CLK               (CLK),
		.RESETN            (RESETN),
		.HOST_WR           (HOST_WR),
		.HOST_RD           (HOST_RD),
		.HOST_A0           (HOST_A0),
		.HOST_DIN          (HOST_DIN),
		.HOST_DOUT         (HOST_DOUT),
		.RESUME_DETECTED   (RESUME_DETECTED),
		.DOWNSTREAM_RESUME (DOWNSTREAM_RESUME),
		.SCHED_OVERRUN     (SCHED_OVERRUN),
		.REMOTE_WAKEUP     (REMOTE_WAKEUP),
		.SOF_ENABLE        (SOF_ENABLE),
		.FUNCTIONAL_STATE  (FUNCTIONAL_STATE),
		.ROOT_HUB_RESET    (ROOT_HUB_RESET),
		.SOFT_RESET        (SOFT_RESET)
	);
	always #20 CLK = ~CLK;
	// read data is looked at once it has settled after the edge
	always @(posedge CLK) if (smp) begin
		#1;
		e = exp_q.pop_front();
		`CHK(HOST_DOUT, e)
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task tick(input int k); repeat (k) @(negedge CLK); endtask
	task wr(input logic a0, input logic [15:0] d);
		@(negedge CLK);
		HOST_WR = 1;
		HOST_A0 = a0;
		HOST_DIN = d;
	endtask
	task wreg(input logic [7:0] c, input logic [31:0] v);
		wr(1, {8'h0, c});
		wr(0, v[15:0]);
		wr(0, v[31:16]);
		tick(1);
		HOST_WR = 0;
	endtask
	task rreg(input logic [7:0] c, input logic [31:0] v);
		wr(1, {8'h0, c});
		smp = 1;
		exp_q.push_back(v[15:0]);
		tick(1);
		HOST_WR = 0;
		HOST_RD = 1;
		HOST_A0 = 0;
		exp_q.push_back(v[31:16]);
		tick(1);
		HOST_RD = 0;
		smp = 0;
	endtask
	task pulse(input int k);
		repeat (k) begin
			SCHED_OVERRUN = 1;
			tick(1);
			SCHED_OVERRUN = 0;
			tick(1);
		end
	endtask
	task wait_hi(input bit sel, input int lim);
		n = 0;
		while ((sel ? SOFT_RESET : SOF_ENABLE) !== 1'b1) begin
			@(posedge CLK);
			#1;
			n++;
			if (n > lim) begin
				num_errors++;
				$display("mismatch t=%0t wait timed out", $time);
				wrap_up();
			end
		end
	endtask
	task done(input string s); $display("test %s done", s); endtask
	task wrap_up;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		tick(11);
		`CHK(ROOT_HUB_RESET, 1'b1)
		tick(1);
		RESETN = 1;
		tick(4);
		`CHK(ROOT_HUB_RESET, 1'b0)
		`CHK(FUNCTIONAL_STATE, STATE_BUS_RESET)
		rreg(CMD_CTRL_RD, 32'h0);
		rreg(CMD_CSTAT_RD, 32'h0);
		done("reset");
		w = (rnd() & 32'hffff_ff3f) | 32'h280;
		wreg(CMD_CTRL_WR, w);
		wait_hi(0, SD + 8);
		`CHK((n >= SD - 1) && (n <= SD + 1), 1'b1)
		rreg(CMD_CTRL_RD, w & 32'h6c0);
		for (int i = 0; i < 2; i++) begin
			RESUME_DETECTED = i[0];
			tick(1);
			`CHK(REMOTE_WAKEUP, i[0] & w[10])
		end
		DOWNSTREAM_RESUME = 1;
		tick(1);
		DOWNSTREAM_RESUME = 0;
		tick(1);
		`CHK(FUNCTIONAL_STATE, STATE_OPERATIONAL)
		done("operational");
		wreg(CMD_CTRL_WR, w | 32'hc0);
		tick(3);
		`CHK(SOF_ENABLE, 1'b0)
		`CHK(FUNCTIONAL_STATE, STATE_SUSPEND)
		DOWNSTREAM_RESUME = 1;
		tick(1);
		DOWNSTREAM_RESUME = 0;
		tick(1);
		`CHK(FUNCTIONAL_STATE, STATE_RESUME)
		rreg(CMD_CTRL_RD, (w & 32'h600) | 32'h40);
		done("suspend");
		pulse(3);
		wreg(CMD_CSTAT_WR, 32'hfffe_fffe);
		rreg(CMD_CSTAT_RD, 32'h3_0000);
		pulse(2);
		rreg(CMD_CSTAT_RD, 32'h1_0000);
		wreg(CMD_CSTAT_WR, 32'h1);
		wait_hi(1, 8);
		`CHK(FUNCTIONAL_STATE, STATE_BUS_RESET)
		`CHK(ROOT_HUB_RESET, 1'b0)
		`CHK(REMOTE_WAKEUP, 1'b0)
		rreg(CMD_CTRL_RD, 32'h200);
		rreg(CMD_CSTAT_RD, 32'h0);
		done("command status");
		RESETN = 0;
		tick(2);
		`CHK(ROOT_HUB_RESET, 1'b1)
		RESETN = 1;
		tick(4);
		rreg(CMD_CTRL_RD, 32'h0);
		rreg(8'h03, 32'h0);
		done("hardware reset");
		wrap_up();
	end
endmodule // uhc_command_regs_tb
`default_nettype wire
